// [logic/rcsr_defs.svh]
`ifndef RCSR_DEFS_SVH
`define RCSR_DEFS_SVH

// Register offsets (byte addresses on the plain register port)
`define RCSR_ADDR_STATUS 8'h00
`define RCSR_ADDR_IRQ_STAT 8'h04
`define RCSR_ADDR_IRQ_MASK 8'h08

// Field positions inside the reset cause register
`define RCSR_BIT_POR 0
`define RCSR_BIT_BROWNOUT 1
`define RCSR_BIT_IDLE 2
`define RCSR_BIT_SLEEP 3
`define RCSR_BIT_WATCHDOG 4
`define RCSR_BIT_SOFTWARE 6
`define RCSR_BIT_EXT_PIN 7
`define RCSR_BIT_REG_STANDBY 8
`define RCSR_BIT_CFG_MISMATCH 9

// Implemented bits and power-on value
`define RCSR_IMPL_MASK 32'h0000_03df
`define RCSR_FLAG_MASK 32'h0000_02df
`define RCSR_RESET_VALUE 32'h0000_0003

`endif

// [logic/rcsr_pkg.sv]
package rcsr_pkg;

  // Register state of the reset cause block
  typedef struct packed {
    logic [9:0] ev_meta;
    logic [9:0] ev_seen;
    logic [9:0] cause;
    logic [9:0] irq_stat;
    logic [9:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
    logic standby_out;
  } rcsr_state_t;

endpackage

// [logic/rcsr_top.sv]
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rcsr_defs.svh"

module rcsr_top
  import rcsr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output var logic [31:0] RDATA,
  input wire logic EV_CFG_MISMATCH,
  input wire logic EV_EXT_PIN,
  input wire logic EV_SOFTWARE,
  input wire logic EV_WATCHDOG,
  input wire logic EV_SLEEP_WAKE,
  input wire logic EV_IDLE_WAKE,
  input wire logic EV_BROWNOUT,
  input wire logic EV_POWERON,
  output var logic REG_STANDBY_ENABLE,
  output var logic IRQ
);

  rcsr_state_t r; // Current state
  rcsr_state_t next_r; // Next state
  logic [9:0] ev_raw; // Raw events in register layout
  logic [9:0] ev; // Synchronised events
  logic [9:0] wmask; // Writable bits of the cause register

  // Map event inputs onto their bit positions; bit 5 and 8 never set
  always_comb
  begin
    ev_raw = '0;
    ev_raw[`RCSR_BIT_CFG_MISMATCH] = EV_CFG_MISMATCH;
    ev_raw[`RCSR_BIT_EXT_PIN] = EV_EXT_PIN;
    ev_raw[`RCSR_BIT_SOFTWARE] = EV_SOFTWARE;
    ev_raw[`RCSR_BIT_WATCHDOG] = EV_WATCHDOG;
    ev_raw[`RCSR_BIT_SLEEP] = EV_SLEEP_WAKE;
    ev_raw[`RCSR_BIT_IDLE] = EV_IDLE_WAKE;
    ev_raw[`RCSR_BIT_BROWNOUT] = EV_BROWNOUT;
    ev_raw[`RCSR_BIT_POR] = EV_POWERON;
  end

  // Second synchroniser stage is the only reader of the first
  assign ev = r.ev_seen;
  assign wmask = 10'(`RCSR_IMPL_MASK);

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Next state: events set, software writes, read-clear of irq status
  always_comb
  begin
    next_r = r;
    next_r.rdata = '0;
    // Events come from other reset logic, so they pass two flops first
    next_r.ev_meta = ev_raw;
    next_r.ev_seen = r.ev_meta;
    // Software write to cause register; reserved bits discarded
    if (WR && hit(ADDR, `RCSR_ADDR_STATUS))
      next_r.cause = WDATA[9:0] & wmask;
    if (WR && hit(ADDR, `RCSR_ADDR_IRQ_MASK))
      next_r.irq_mask = WDATA[9:0] & 10'(`RCSR_FLAG_MASK);
    // Hardware sets come last so an event beats a clearing write
    next_r.cause = next_r.cause | ev;
    // Read data, one cycle later; unmapped addresses read zero
    if (RD)
    begin
      if (hit(ADDR, `RCSR_ADDR_STATUS))
        next_r.rdata = {22'h0, r.cause};
      else if (hit(ADDR, `RCSR_ADDR_IRQ_STAT))
        next_r.rdata = {22'h0, r.irq_stat};
      else if (hit(ADDR, `RCSR_ADDR_IRQ_MASK))
        next_r.rdata = {22'h0, r.irq_mask};
    end
    // Interrupt status clears on read, but a new event still lands
    if (RD && hit(ADDR, `RCSR_ADDR_IRQ_STAT))
      next_r.irq_stat = '0;
    next_r.irq_stat = next_r.irq_stat | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
    next_r.standby_out = next_r.cause[`RCSR_BIT_REG_STANDBY];
  end

  // State register; power-on value has brown-out and power-on flags set
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      r <= '0;
      r.cause <= 10'(`RCSR_RESET_VALUE);
    end
    else
      r <= next_r;
  end

  assign RDATA = r.rdata;
  assign REG_STANDBY_ENABLE = r.standby_out;
  assign IRQ = r.irq;

  // A synchronised event shows in the cause register next cycle
  property p_event_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_CFG_MISMATCH] |=> r.cause[`RCSR_BIT_CFG_MISMATCH];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("mismatch flag not set");

  property p_ext_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_EXT_PIN] |=> r.cause[`RCSR_BIT_EXT_PIN];
  endproperty
  a_ext_sets: assert property (p_ext_sets) else $error("pin flag not set");

  property p_wdt_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_WATCHDOG] |=> r.cause[`RCSR_BIT_WATCHDOG];
  endproperty
  a_wdt_sets: assert property (p_wdt_sets) else $error("watchdog flag not set");

  // Event input reaches the flag within three edges
  sequence s_por_pulse;
    EV_POWERON ##1 1'b1;
  endsequence
  property p_por_path;
    @(posedge REF_CLK) disable iff (RESET)
      s_por_pulse |-> ##[1:2] r.cause[`RCSR_BIT_POR];
  endproperty
  a_por_path: assert property (p_por_path) else $error("power-on flag missed");

  // Reserved bits always read zero
  property p_reserved_zero;
    @(posedge REF_CLK) disable iff (RESET)
      RDATA[31:10] == 22'h0 && !RDATA[5];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  // Flag stays set without a write
  property p_sticky;
    @(posedge REF_CLK) disable iff (RESET)
      r.cause[`RCSR_BIT_BROWNOUT] && !WR |=> r.cause[`RCSR_BIT_BROWNOUT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("brown-out flag lost");

  // Clearing write loses to a simultaneous event
  property p_set_wins;
    @(posedge REF_CLK) disable iff (RESET)
      WR && ADDR == `RCSR_ADDR_STATUS && ev[`RCSR_BIT_SOFTWARE]
        |=> r.cause[`RCSR_BIT_SOFTWARE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  // Standby control follows a written bit 8 on the next edge
  property p_standby;
    @(posedge REF_CLK) disable iff (RESET)
      WR && ADDR == `RCSR_ADDR_STATUS |=> ##0
        REG_STANDBY_ENABLE == $past(WDATA[`RCSR_BIT_REG_STANDBY]);
  endproperty
  a_standby: assert property (p_standby) else $error("standby control wrong");

  // Read of cause register returns state of previous cycle
  property p_read;
    @(posedge REF_CLK) disable iff (RESET)
      RD && ADDR == `RCSR_ADDR_STATUS |=> RDATA == {22'h0, $past(r.cause)};
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_wake;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_SLEEP] || ev[`RCSR_BIT_IDLE]
        |=> r.cause[`RCSR_BIT_SLEEP] || r.cause[`RCSR_BIT_IDLE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag missed");

  // Software reset event sets its flag
  property p_sw_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_SOFTWARE] |=> r.cause[`RCSR_BIT_SOFTWARE];
  endproperty
  a_sw_sets: assert property (p_sw_sets) else $error("software flag not set");

  // Wake from sleep sets its own flag
  property p_sleep_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_SLEEP] |=> r.cause[`RCSR_BIT_SLEEP];
  endproperty
  a_sleep_sets: assert property (p_sleep_sets) else $error("sleep flag not set");

  // Wake from idle sets its own flag
  property p_idle_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_IDLE] |=> r.cause[`RCSR_BIT_IDLE];
  endproperty
  a_idle_sets: assert property (p_idle_sets) else $error("idle flag not set");

  // Brown-out event sets its flag
  property p_bor_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_BROWNOUT] |=> r.cause[`RCSR_BIT_BROWNOUT];
  endproperty
  a_bor_sets: assert property (p_bor_sets) else $error("brown-out flag not set");

  // Power-on event sets its flag
  property p_por_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev[`RCSR_BIT_POR] |=> r.cause[`RCSR_BIT_POR];
  endproperty
  a_por_sets: assert property (p_por_sets) else $error("power-on flag not set");

  // Mismatch flag stays clear without event or any write
  property p_cfg_hold;
    @(posedge REF_CLK) disable iff (RESET)
      !r.cause[`RCSR_BIT_CFG_MISMATCH] && !ev[`RCSR_BIT_CFG_MISMATCH] && !WR
        |=> !r.cause[`RCSR_BIT_CFG_MISMATCH];
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("mismatch flag set");

  // One write strobe to the cause register
  sequence s_status_write;
    WR && ADDR == `RCSR_ADDR_STATUS;
  endsequence

  // A read of interrupt status with no event arriving
  sequence s_stat_read;
    RD && ADDR == `RCSR_ADDR_IRQ_STAT && ev == 10'h0;
  endsequence

  // One write strobe to the mask register
  sequence s_mask_write;
    WR && ADDR == `RCSR_ADDR_IRQ_MASK;
  endsequence

  // Software clear of the brown-out flag lands when no event races it
  property p_clear;
    @(posedge REF_CLK) disable iff (RESET)
      WR && ADDR == `RCSR_ADDR_STATUS && !WDATA[`RCSR_BIT_BROWNOUT]
        && !ev[`RCSR_BIT_BROWNOUT] |=> !r.cause[`RCSR_BIT_BROWNOUT];
  endproperty
  a_clear: assert property (p_clear) else $error("flag clear lost");

  // Standby control moves only on a cause register write
  property p_standby_hold;
    @(posedge REF_CLK) disable iff (RESET)
      !WR |=> $stable(REG_STANDBY_ENABLE);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby moved");

  // Unimplemented positions never hold a one
  property p_bit5;
    @(posedge REF_CLK) disable iff (RESET)
      !r.cause[5] && !r.irq_mask[5] && !r.irq_mask[8] && !r.irq_stat[5];
  endproperty
  a_bit5: assert property (p_bit5) else $error("unimplemented bit set");

  // Read data is zero outside the cycle after a read
  property p_rdata_idle;
    @(posedge REF_CLK) disable iff (RESET)
      !RD |=> RDATA == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

  // Unmapped addresses read zero
  property p_unmapped;
    @(posedge REF_CLK) disable iff (RESET)
      RD && ADDR != `RCSR_ADDR_STATUS && ADDR != `RCSR_ADDR_IRQ_STAT
        && ADDR != `RCSR_ADDR_IRQ_MASK |=> RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Interrupt line mirrors unmasked pending status
  property p_irq_level;
    @(posedge REF_CLK) disable iff (RESET)
      IRQ == |(r.irq_stat & r.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  // Status read clears pending interrupts when nothing new arrives
  property p_stat_read;
    @(posedge REF_CLK) disable iff (RESET)
      s_stat_read |=> r.irq_stat == 10'h0;
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status not cleared");

  // Mask write keeps only the flag positions
  property p_mask_write;
    @(posedge REF_CLK) disable iff (RESET)
      s_mask_write |=> r.irq_mask == ($past(WDATA[9:0]) & 10'(`RCSR_FLAG_MASK));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

  // Every event also lands in interrupt status, even during a read-clear
  property p_stat_sets;
    @(posedge REF_CLK) disable iff (RESET)
      ev != 10'h0 |=> (r.irq_stat & $past(ev)) == $past(ev);
  endproperty
  a_stat_sets: assert property (p_stat_sets) else $error("status event lost");

  // First edge after reset sees the power-on state
  property p_reset_state;
    @(posedge REF_CLK)
      $fell(RESET) |-> r.cause == 10'(`RCSR_RESET_VALUE) && RDATA == 32'h0 && !IRQ;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  // Power-on flag stays set without a write
  property p_por_sticky;
    @(posedge REF_CLK) disable iff (RESET)
      r.cause[`RCSR_BIT_POR] && !WR |=> r.cause[`RCSR_BIT_POR];
  endproperty
  a_por_sticky: assert property (p_por_sticky) else $error("power-on flag lost");

  // A masked-on event raises the interrupt line
  property p_irq_rise;
    @(posedge REF_CLK) disable iff (RESET)
      (ev & r.irq_mask) != 10'h0 |=> IRQ;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt not raised");

  // Mask register reads back its previous contents
  property p_mask_read;
    @(posedge REF_CLK) disable iff (RESET)
      RD && ADDR == `RCSR_ADDR_IRQ_MASK |=> RDATA == {22'h0, $past(r.irq_mask)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  // Interrupt status reads back before it is cleared
  property p_stat_data;
    @(posedge REF_CLK) disable iff (RESET)
      RD && ADDR == `RCSR_ADDR_IRQ_STAT |=> RDATA == {22'h0, $past(r.irq_stat)};
  endproperty
  a_stat_data: assert property (p_stat_data) else $error("status read wrong");

  // Any cause register write sets standby control to the written bit 8
  property p_standby_set;
    @(posedge REF_CLK) disable iff (RESET)
      s_status_write |=> REG_STANDBY_ENABLE == $past(WDATA[`RCSR_BIT_REG_STANDBY]);
  endproperty
  a_standby_set: assert property (p_standby_set) else $error("standby not set");

endmodule // rcsr_top

`default_nettype wire

// [dv/rcsr_event_src.sv]
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the reset and wake sources around the block
module rcsr_event_src (
  input wire logic clk,
  input wire logic [7:0] req,
  output logic [7:0] ev
);
  // Sources launch from flops, so the block sees clean edges
  always_ff @(posedge clk)
  begin
    ev <= req;
  end
endmodule // rcsr_event_src
`default_nettype wire

// [dv/rcsr_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module rcsr_top_test;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, stby, irq;
  logic [7:0] addr = '0, req = '0, ev;
  logic [31:0] wdata = '0, rdata, w;
  int fail_count = 0, tests_run = 0, cyc = 0;
  int pos[8] = '{0, 1, 2, 3, 4, 6, 7, 9}; // Cause bit of each event line
  logic [31:0] exp_q[$]; // Read results still owed
  always #10 clk = ~clk; // 50 MHz
  rcsr_event_src rcsr_event_src_i (.clk(clk), .req(req), .ev(ev));
  rcsr_top rcsr_top_i (.REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .EV_CFG_MISMATCH(ev[7]), .EV_EXT_PIN(ev[6]),
    .EV_SOFTWARE(ev[5]), .EV_WATCHDOG(ev[4]), .EV_SLEEP_WAKE(ev[3]),
    .EV_IDLE_WAKE(ev[2]), .EV_BROWNOUT(ev[1]), .EV_POWERON(ev[0]),
    .REG_STANDBY_ENABLE(stby), .IRQ(irq));
  task automatic chk32(input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected RDATA exp %h seen %h", e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %b seen %b", n, e, s);
    end
  endtask
  // One bus cycle; a read notes its expected word for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  task automatic fire(input logic [7:0] r, input int n);
    req <= r;
    repeat (n) @(posedge clk);
    req <= '0;
    repeat (5) @(posedge clk);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
    rd_d <= rd;
  always @(negedge clk)
  begin
    if (rd_d)
      chk32(exp_q.pop_front(), rdata);
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    w = $urandom(83);
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    bus(0, 8'h00, 32'h0000_0003);
    bus(0, 8'h0c, 32'h0);
    $display("reset values done");
    w = $urandom;
    bus(1, 8'h00, w);
    chk1("standby", w[8], stby);
    bus(0, 8'h00, w & 32'h0000_03df);
    $display("write mask done");
    for (int i = 0; i < 8; i++)
    begin
      bus(1, 8'h00, 32'h0);
      fire(8'h01 << i, 1);
      bus(0, 8'h00, 32'h1 << pos[i]);
    end
    $display("event flags done");
    bus(1, 8'h00, 32'h0);
    req <= 8'h40;
    repeat (4) @(posedge clk);
    bus(1, 8'h00, 32'h0);
    fire(8'h40, 1);
    bus(0, 8'h00, 32'h0000_0080);
    $display("set over clear done");
    bus(0, 8'h04, 32'h0000_02df);
    bus(1, 8'h08, 32'h0000_0010);
    fire(8'h04, 2);
    chk1("irq", 1'b0, irq);
    fire(8'h10, 2);
    chk1("irq", 1'b1, irq);
    bus(0, 8'h04, 32'h0000_0014);
    chk1("irq", 1'b0, irq);
    $display("interrupt done");
    complete_run;
  end
endmodule // rcsr_top_test
`default_nettype wire
